// *** nvh_pkg.sv ***
// Shared constants for the note validator serial, pulse and discrete link
// Operation
// - Note entry sends busy code 120 first
// - Accepted note sends 121 then channel number
// - Unknown note: 121, 20, then 121 after return
// - Code 134 inhibits channel 4, echoed back
// - Code 154 re-enables channel 4, echoed back
// - Status request 182 echoed, then three bytes
// - Status bytes one, two: inhibit flags 1-16
// - Third status byte: escrow on one, off zero
// - Code 172 accepts held note, echo plus channel
// - Pulse mode emits configured pulses, configurable duty
// - Inhibit inputs pulled high; host drives low
// - No inhibit low means global disable
// - Busy output low while handling a note
// - Low power six seconds after power-up
// - Low power again one second after note
// - Credit hold: pulse unit after escrow rise
// - Credit hold repeats until full credit paid
// - Busy low and inhibited during credit hold
// - Escrow holds note; returned after 30 seconds
// - Byte frame: start, eight data, two stops
// - Slow variant 300 baud, fast 9600 baud
package nvh_pkg;
  // ----------------------------------------
  // Clock and serial timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_SLOW = 300;
  localparam int BAUD_FAST = 9600;
  localparam logic [15:0] DIV_SLOW = 16'(CLK_HZ / BAUD_SLOW);
  localparam logic [15:0] DIV_FAST = 16'(CLK_HZ / BAUD_FAST);
  localparam logic [3:0] FRAME_BITS = 4'hb;
  localparam logic [3:0] RX_STOP_IDX = 4'h9;
  // ----------------------------------------
  // Long delays, seconds and cycles
  // ----------------------------------------
  localparam int SLEEP_FIRST_S = 6;
  localparam int SLEEP_AFTER_S = 1;
  localparam int ESCROW_TMO_S = 30;
  localparam int SLEEP_FIRST_CYC = SLEEP_FIRST_S * CLK_HZ;
  localparam int SLEEP_AFTER_CYC = SLEEP_AFTER_S * CLK_HZ;
  localparam int ESCROW_TMO_CYC = ESCROW_TMO_S * CLK_HZ;
  typedef logic [28:0] nvh_tmr_t;
  // ----------------------------------------
  // Event and command codes
  // ----------------------------------------
  localparam logic [7:0] EV_BUSY = 8'h78;
  localparam logic [7:0] EV_READY = 8'h79;
  localparam logic [7:0] EV_NOTREC = 8'h14;
  localparam logic [7:0] EV_CMD_ERR = 8'hff;
  localparam logic [7:0] CMD_INH_FIRST = 8'h83;
  localparam logic [7:0] CMD_INH_LAST = 8'h92;
  localparam logic [7:0] CMD_UNINH_FIRST = 8'h97;
  localparam logic [7:0] CMD_UNINH_LAST = 8'ha6;
  localparam logic [7:0] CMD_ESC_ON = 8'haa;
  localparam logic [7:0] CMD_ESC_OFF = 8'hab;
  localparam logic [7:0] CMD_ESC_ACC = 8'hac;
  localparam logic [7:0] CMD_ESC_REJ = 8'had;
  localparam logic [7:0] CMD_STATUS = 8'hb6;
  localparam logic [7:0] CMD_EN_ALL = 8'hb8;
  localparam logic [7:0] CMD_DIS_ALL = 8'hb9;
  // ----------------------------------------
  // Host controller registers (APB)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0c;
  localparam logic [7:0] REG_CREDIT = 8'h10;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_FAST = 0;
  localparam int CTRL_ESC = 1;
  localparam int CTRL_ENA_LSB = 4;
  localparam int STAT_RXV = 0;
  localparam int STAT_TXB = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_OVR = 3;
  localparam int STAT_TXP = 4;

  // Inclusive code range check
  function automatic logic inRange(input logic [7:0] c, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction
endpackage

// *** nvh_link_if.sv ***
// Validator-to-host link: serial pair, credit pulse and discrete lines
interface nvh_link_if;
  logic devTx;
  logic hostTx;
  logic vend;
  logic busyN;
  logic escrow;
  logic [3:0] inhOut;
  logic [3:0] inhOeN;
  logic [3:0] inhLine;
  // Open-drain inhibit lines with pull-up: undriven reads high
  assign inhLine = inhOeN | inhOut;
  modport dev (input hostTx, input inhLine, input escrow,
               output devTx, output vend, output busyN);
  modport host (output hostTx, output inhOut, output inhOeN, output escrow,
                input devTx, input vend, input busyN);
endinterface

// *** nvh_device.sv ***
// Validator end: serial byte engine and note handling sequencer
module nvh_uart
  import nvh_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic fast,
  // Line
  input wire logic rxPin,
  output logic txPin,
  // Byte side
  input wire logic txGo,
  input wire logic [7:0] txByte,
  output logic txBusy,
  output logic rxValid,
  output logic [7:0] rxByte
);
  logic [15:0] txCnt_ff, rxCnt_ff;
  logic [3:0] txBit_ff, rxBit_ff;
  logic [10:0] txSh_ff;
  logic [7:0] rxSh_ff;
  logic rxS1_ff, rxS2_ff, rxAct_ff, rxValid_ff;
  wire [15:0] div = fast ? DIV_FAST : DIV_SLOW;
  wire txTick = txCnt_ff == div - 16'h0001;
  assign txPin = txSh_ff[0];
  assign txBusy = txBit_ff != 4'h0;
  assign rxValid = rxValid_ff;
  assign rxByte = rxSh_ff;

  // Transmit: start, eight data LSB first, two stops
  always_ff @(posedge clk) begin
    if (rst) begin
      txSh_ff <= 11'h7ff;
      txBit_ff <= 4'h0;
      txCnt_ff <= 16'h0000;
    end else if (txGo && !txBusy) begin
      txSh_ff <= {2'b11, txByte, 1'b0};
      txBit_ff <= FRAME_BITS;
      txCnt_ff <= 16'h0000;
    end else if (txBusy) begin
      txCnt_ff <= txTick ? 16'h0000 : txCnt_ff + 16'h0001;
      if (txTick) begin
        txSh_ff <= {1'b1, txSh_ff[10:1]};
        txBit_ff <= txBit_ff - 4'h1;
      end
    end
  end

  // Receive: sample mid-bit, drop false starts and bad stops
  always_ff @(posedge clk) begin
    if (rst) begin
      rxS1_ff <= 1'b1;
      rxS2_ff <= 1'b1;
      rxAct_ff <= 1'b0;
      rxValid_ff <= 1'b0;
      rxCnt_ff <= 16'h0000;
      rxBit_ff <= 4'h0;
      rxSh_ff <= 8'h00;
    end else begin
      rxS1_ff <= rxPin;
      rxS2_ff <= rxS1_ff;
      rxValid_ff <= 1'b0;
      if (!rxAct_ff) begin
        if (!rxS2_ff) begin
          rxAct_ff <= 1'b1;
          rxCnt_ff <= {1'b0, div[15:1]};
          rxBit_ff <= 4'h0;
        end
      end else if (rxCnt_ff != 16'h0000) begin
        rxCnt_ff <= rxCnt_ff - 16'h0001;
      end else begin
        rxCnt_ff <= div - 16'h0001;
        rxBit_ff <= rxBit_ff + 4'h1;
        if (rxBit_ff == 4'h0 && rxS2_ff) begin
          rxAct_ff <= 1'b0;
        end else if (rxBit_ff == RX_STOP_IDX) begin
          rxAct_ff <= 1'b0;
          rxValid_ff <= rxS2_ff;
        end else if (rxBit_ff != 4'h0) begin
          rxSh_ff <= {rxS2_ff, rxSh_ff[7:1]};
        end
      end
    end
  end
endmodule

module nvh_device
  import nvh_pkg::*;
#(
  parameter int SLEEP_FIRST = SLEEP_FIRST_CYC,
  parameter int SLEEP_AFTER = SLEEP_AFTER_CYC,
  parameter int ESC_TMO = ESCROW_TMO_CYC
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  nvh_link_if.dev link,
  // Configuration
  input wire logic fastBaud,
  input wire logic pulseMode,
  input wire logic creditHold,
  input wire logic lowPowerEn,
  input wire logic escrowPinEn,
  input wire logic [7:0] pulsesPerUnit,
  input wire logic [15:0] pulseHigh,
  input wire logic [15:0] pulseLow,
  // Note sensor
  input wire logic noteEnter,
  input wire logic noteResult,
  input wire logic noteOk,
  input wire logic [3:0] noteChan,
  input wire logic [7:0] noteUnits,
  input wire logic noteReturned,
  // Mechanism
  output logic stackNote,
  output logic returnNote,
  output logic globalDisable,
  output logic lowPower,
  output logic [15:0] chanInhibit
);
  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_ENTER = 10'h002, S_SENSE = 10'h004, S_REPORT = 10'h008,
    S_ESCROW = 10'h010, S_CREDIT = 10'h020, S_HOLD = 10'h040, S_PULSE = 10'h080,
    S_RETURN = 10'h100, S_REREADY = 10'h200
  } nvh_state_t;

  nvh_state_t state_ff, nxt_state;
  logic [4:0] pinS1_ff, pinS2_ff;
  logic escPrev_ff, cmdPend_ff, escOn_ff, good_ff, txGo_ff, busyN_ff, vend_ff;
  logic stack_ff, return_ff, lowPower_ff, firstNap_ff, nxt_stack, nxt_return;
  logic [7:0] cmdByte_ff, txByte_ff, units_ff, unitsLeft_ff, pulsesLeft_ff;
  logic [3:0] chan_ff;
  logic [15:0] chanInh_ff, phase_ff;
  logic [31:0] msg_ff, fsmData;
  logic [2:0] qCnt_ff, fsmLen;
  logic fsmLoad;
  nvh_tmr_t tmr_ff;
  wire txBusy, rxValid;
  wire [7:0] rxByte;

  nvh_uart u_uart (
    .clk(clk), .rst(rst), .fast(fastBaud), .rxPin(link.hostTx), .txPin(link.devTx),
    .txGo(txGo_ff), .txByte(txByte_ff), .txBusy(txBusy), .rxValid(rxValid),
    .rxByte(rxByte)
  );

  // Discrete pins and inhibit mask
  wire [3:0] inhPin = pinS2_ff[3:0];
  wire escRise = pinS2_ff[4] & ~escPrev_ff;
  wire [15:0] effInh = chanInh_ff | {12'h000, inhPin};
  wire [7:0] chanCode = 8'(chan_ff) + 8'h01;
  assign globalDisable = &inhPin;
  assign chanInhibit = effInh;
  assign link.busyN = busyN_ff;
  assign link.vend = vend_ff;
  assign stackNote = stack_ff;
  assign returnNote = return_ff;
  assign lowPower = lowPower_ff;

  // Command decode; pending command waits for an empty message queue
  wire [7:0] cmd = cmdByte_ff;
  wire isInh = inRange(cmd, CMD_INH_FIRST, CMD_INH_LAST);
  wire isUninh = inRange(cmd, CMD_UNINH_FIRST, CMD_UNINH_LAST);
  wire [3:0] cmdChan = isInh ? 4'(cmd - CMD_INH_FIRST) : 4'(cmd - CMD_UNINH_FIRST);
  wire isStat = cmd == CMD_STATUS;
  wire isAcc = cmd == CMD_ESC_ACC && state_ff == S_ESCROW;
  wire isRej = cmd == CMD_ESC_REJ && state_ff == S_ESCROW;
  wire known = isInh | isUninh | isStat | isAcc | isRej | cmd == CMD_ESC_ON
             | cmd == CMD_ESC_OFF | cmd == CMD_EN_ALL | cmd == CMD_DIS_ALL;
  wire cmdLoad = cmdPend_ff && qCnt_ff == 3'h0 && !fsmLoad;
  wire escAcc = cmdLoad && isAcc;
  wire escRej = cmdLoad && isRej;
  wire [31:0] cmdData = isStat ? {7'h00, escOn_ff, effInh[15:8], effInh[7:0], cmd}
                      : isAcc ? {16'h0000, chanCode, cmd}
                      : {24'h000000, known ? cmd : EV_CMD_ERR};
  wire [2:0] cmdLen = isStat ? 3'h4 : isAcc ? 3'h2 : 3'h1;
  wire txFire = qCnt_ff != 3'h0 && !txBusy && !txGo_ff;

  // Pulse burst and timer decode
  wire burstEnd = state_ff == S_PULSE && !vend_ff && phase_ff == pulseLow - 16'h0001
                && pulsesLeft_ff == 8'h01;
  wire burstLoad = nxt_state == S_PULSE && (state_ff != S_PULSE || burstEnd);
  wire napHit = tmr_ff == nvh_tmr_t'((firstNap_ff ? SLEEP_FIRST : SLEEP_AFTER) - 1);
  wire escTmo = tmr_ff == nvh_tmr_t'(ESC_TMO - 1);

  // Note sequencer
  always_comb begin
    nxt_state = state_ff;
    fsmLoad = 1'b0;
    fsmData = 32'h00000000;
    fsmLen = 3'h0;
    nxt_stack = 1'b0;
    nxt_return = 1'b0;
    case (state_ff)
      S_IDLE: if (noteEnter && !globalDisable) nxt_state = S_ENTER;
      S_ENTER: if (qCnt_ff == 3'h0) begin
        fsmLoad = 1'b1;
        fsmData = {24'h000000, EV_BUSY};
        fsmLen = 3'h1;
        nxt_state = S_SENSE;
      end
      S_SENSE: if (noteResult) nxt_state = S_REPORT;
      S_REPORT: if (qCnt_ff == 3'h0) begin
        fsmLoad = 1'b1;
        fsmLen = 3'h2;
        if (good_ff) begin
          fsmData = {16'h0000, chanCode, EV_READY};
          nxt_state = (escOn_ff || escrowPinEn) ? S_ESCROW : S_CREDIT;
        end else begin
          fsmData = {16'h0000, EV_NOTREC, EV_READY};
          nxt_return = 1'b1;
          nxt_state = S_RETURN;
        end
      end
      S_ESCROW: if (escAcc || (escrowPinEn && escRise)) begin
        nxt_state = S_CREDIT;
      end else if (escRej || escTmo) begin
        nxt_return = 1'b1;
        nxt_state = S_RETURN;
      end
      S_CREDIT: begin
        nxt_stack = 1'b1;
        nxt_state = !pulseMode ? S_IDLE : creditHold ? S_HOLD : S_PULSE;
      end
      S_HOLD: if (escRise) nxt_state = S_PULSE;
      S_PULSE: if (burstEnd) begin
        nxt_state = unitsLeft_ff == 8'h01 ? S_IDLE : creditHold ? S_HOLD : S_PULSE;
      end
      S_RETURN: if (noteReturned) nxt_state = S_REREADY;
      S_REREADY: if (qCnt_ff == 3'h0) begin
        fsmLoad = 1'b1;
        fsmData = {24'h000000, EV_READY};
        fsmLen = 3'h1;
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // State, pins, note result and strobes
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      pinS1_ff <= 5'h1f;
      pinS2_ff <= 5'h1f;
      escPrev_ff <= 1'b1;
      busyN_ff <= 1'b1;
      stack_ff <= 1'b0;
      return_ff <= 1'b0;
      good_ff <= 1'b0;
      chan_ff <= 4'h0;
      units_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      pinS1_ff <= {link.escrow, link.inhLine};
      pinS2_ff <= pinS1_ff;
      escPrev_ff <= pinS2_ff[4];
      busyN_ff <= nxt_state == S_IDLE;
      stack_ff <= nxt_stack;
      return_ff <= nxt_return;
      if (state_ff == S_SENSE && noteResult) begin
        good_ff <= noteOk && !effInh[noteChan];
        chan_ff <= noteChan;
        units_ff <= noteUnits;
      end
    end
  end

  // Commands: inhibit mask, escrow mode; a new byte wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdPend_ff <= 1'b0;
      cmdByte_ff <= 8'h00;
      chanInh_ff <= 16'h0000;
      escOn_ff <= 1'b0;
    end else begin
      if (rxValid) begin
        cmdPend_ff <= 1'b1;
        cmdByte_ff <= rxByte;
      end else if (cmdLoad) begin
        cmdPend_ff <= 1'b0;
      end
      if (cmdLoad && isInh) chanInh_ff[cmdChan] <= 1'b1;
      if (cmdLoad && isUninh) chanInh_ff[cmdChan] <= 1'b0;
      if (cmdLoad && cmd == CMD_EN_ALL) chanInh_ff <= 16'h0000;
      if (cmdLoad && cmd == CMD_DIS_ALL) chanInh_ff <= 16'hffff;
      if (cmdLoad && cmd == CMD_ESC_ON) escOn_ff <= 1'b1;
      if (cmdLoad && cmd == CMD_ESC_OFF) escOn_ff <= 1'b0;
    end
  end

  // Outgoing message queue, first byte in the low lane
  always_ff @(posedge clk) begin
    if (rst) begin
      msg_ff <= 32'h00000000;
      qCnt_ff <= 3'h0;
      txGo_ff <= 1'b0;
      txByte_ff <= 8'h00;
    end else begin
      txGo_ff <= txFire;
      if (fsmLoad) begin
        msg_ff <= fsmData;
        qCnt_ff <= fsmLen;
      end else if (cmdLoad) begin
        msg_ff <= cmdData;
        qCnt_ff <= cmdLen;
      end else if (txFire) begin
        txByte_ff <= msg_ff[7:0];
        msg_ff <= {8'h00, msg_ff[31:8]};
        qCnt_ff <= qCnt_ff - 3'h1;
      end
    end
  end

  // Credit pulses: high for pulseHigh cycles, low for pulseLow
  always_ff @(posedge clk) begin
    if (rst) begin
      vend_ff <= 1'b0;
      phase_ff <= 16'h0000;
      pulsesLeft_ff <= 8'h00;
      unitsLeft_ff <= 8'h00;
    end else if (state_ff == S_CREDIT) begin
      unitsLeft_ff <= units_ff;
      vend_ff <= nxt_state == S_PULSE;
      phase_ff <= 16'h0000;
      pulsesLeft_ff <= pulsesPerUnit;
    end else if (burstLoad) begin
      vend_ff <= 1'b1;
      phase_ff <= 16'h0000;
      pulsesLeft_ff <= pulsesPerUnit;
      if (burstEnd) unitsLeft_ff <= unitsLeft_ff - 8'h01;
    end else if (state_ff == S_PULSE) begin
      if (vend_ff && phase_ff == pulseHigh - 16'h0001) begin
        vend_ff <= 1'b0;
        phase_ff <= 16'h0000;
      end else if (!vend_ff && phase_ff == pulseLow - 16'h0001) begin
        vend_ff <= !burstEnd;
        phase_ff <= 16'h0000;
        pulsesLeft_ff <= pulsesLeft_ff - 8'h01;
        if (burstEnd) unitsLeft_ff <= unitsLeft_ff - 8'h01;
      end else begin
        phase_ff <= phase_ff + 16'h0001;
      end
    end else begin
      vend_ff <= 1'b0;
    end
  end

  // Low power and state timer; restarts on every state change
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_ff <= '0;
      lowPower_ff <= 1'b0;
      firstNap_ff <= 1'b1;
    end else begin
      tmr_ff <= (state_ff != nxt_state || lowPower_ff) ? '0 : tmr_ff + 1'b1;
      if (noteEnter) begin
        lowPower_ff <= 1'b0;
      end else if (state_ff == S_IDLE && lowPowerEn && napHit) begin
        lowPower_ff <= 1'b1;
      end
      if (state_ff != S_IDLE || lowPower_ff) firstNap_ff <= 1'b0;
    end
  end
endmodule

// *** nvh_host.sv ***
// Machine controller end: APB registers driving the validator link
module nvh_host
  import nvh_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  nvh_link_if.host link
);
  logic [7:0] ctrl_ff, txData_ff, rxData_ff;
  logic [31:0] prdata_ff;
  logic [15:0] credit_ff;
  logic txPend_ff, txGo_ff, rxv_ff, ovr_ff;
  logic [1:0] vendS_ff, busyS_ff;
  logic vendPrev_ff;
  wire txBusy, rxValid;
  wire [7:0] rxByte;

  nvh_uart u_uart (
    .clk(clk), .rst(rst), .fast(ctrl_ff[CTRL_FAST]), .rxPin(link.devTx),
    .txPin(link.hostTx), .txGo(txGo_ff), .txByte(txData_ff), .txBusy(txBusy),
    .rxValid(rxValid), .rxByte(rxByte)
  );

  // APB decode; the slave never waits
  wire setup = psel && !penable;
  wire acc = psel && penable;
  wire hit = paddr == REG_CTRL || paddr == REG_TX || paddr == REG_STAT
           || paddr == REG_RX || paddr == REG_CREDIT;
  wire wrCtrl = acc && pwrite && paddr == REG_CTRL;
  wire wrTx = acc && pwrite && paddr == REG_TX;
  wire wrCredit = acc && pwrite && paddr == REG_CREDIT;
  wire rdRx = acc && !pwrite && paddr == REG_RX;
  wire vendRise = vendS_ff[1] && !vendPrev_ff;
  wire txFire = txPend_ff && !txBusy && !txGo_ff;
  wire [7:0] stat = {3'h0, txPend_ff, ovr_ff, ~busyS_ff[1], txBusy, rxv_ff};
  wire [31:0] rdMux = paddr == REG_CTRL ? {24'h000000, ctrl_ff}
                    : paddr == REG_STAT ? {24'h000000, stat}
                    : paddr == REG_RX ? {24'h000000, rxData_ff}
                    : paddr == REG_CREDIT ? {16'h0000, credit_ff}
                    : 32'h00000000;
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // Pins: enabled channel lines pulled low, escrow follows its bit
  assign link.inhOut = 4'h0;
  assign link.inhOeN = ~ctrl_ff[CTRL_ENA_LSB +: 4];
  assign link.escrow = ctrl_ff[CTRL_ESC];

  // Control and command byte; a write while one is pending is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
      txData_ff <= 8'h00;
      txPend_ff <= 1'b0;
      txGo_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      txGo_ff <= txFire;
      if (setup) prdata_ff <= rdMux;
      if (wrCtrl) ctrl_ff <= pwdata[7:0];
      if (wrTx && !txPend_ff) begin
        txData_ff <= pwdata[7:0];
        txPend_ff <= 1'b1;
      end else if (txFire) begin
        txPend_ff <= 1'b0;
      end
    end
  end

  // Received bytes and credit count; arrivals win over clears
  always_ff @(posedge clk) begin
    if (rst) begin
      rxData_ff <= 8'h00;
      rxv_ff <= 1'b0;
      ovr_ff <= 1'b0;
      credit_ff <= 16'h0000;
      vendS_ff <= 2'b00;
      busyS_ff <= 2'b11;
      vendPrev_ff <= 1'b0;
    end else begin
      vendS_ff <= {vendS_ff[0], link.vend};
      busyS_ff <= {busyS_ff[0], link.busyN};
      vendPrev_ff <= vendS_ff[1];
      if (rxValid) begin
        rxData_ff <= rxByte;
        rxv_ff <= 1'b1;
        ovr_ff <= ovr_ff | (rxv_ff && !rdRx);
      end else if (rdRx) begin
        rxv_ff <= 1'b0;
        ovr_ff <= 1'b0;
      end
      if (vendRise) begin
        credit_ff <= wrCredit ? 16'h0001 : credit_ff + 16'h0001;
      end else if (wrCredit) begin
        credit_ff <= 16'h0000;
      end
    end
  end
endmodule

// *** nvh_link_chk.sv ***
// Link checker: serial framing, credit pulse shape, busy and inhibit lines
module nvh_link_chk
  import nvh_pkg::*;
#(
  parameter int DIV = int'(DIV_FAST)
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic devTx,
  input wire logic hostTx,
  input wire logic vend,
  input wire logic busyN,
  input wire logic [3:0] inhOut,
  input wire logic [3:0] inhOeN,
  input wire logic [3:0] inhLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Low-run counters
  // ----
  logic [15:0] devLow_ff;
  logic [15:0] hostLow_ff;
  // Runs are too long for repetition, so count them
  wire logic [15:0] nxt_devLow = devTx ? 16'h0 : devLow_ff + 16'h1;
  wire logic [15:0] nxt_hostLow = hostTx ? 16'h0 : hostLow_ff + 16'h1;
  always_ff @(posedge clk) begin
    devLow_ff <= rst ? 16'h0 : nxt_devLow;
    hostLow_ff <= rst ? 16'h0 : nxt_hostLow;
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Low run is whole bits, at most start plus eight zero bits
  AST_DEV_BIT: assert property ($rose(devTx) |->
      devLow_ff % DIV == 0 && devLow_ff <= 9 * DIV)
    else $error("device serial low run not whole bits");
  AST_HOST_BIT: assert property ($rose(hostTx) |->
      hostLow_ff % DIV == 0 && hostLow_ff <= 9 * DIV)
    else $error("host serial low run not whole bits");
  AST_VEND_HI: assert property ($rose(vend) |-> vend[*4] ##1 !vend)
    else $error("credit pulse high time wrong");
  AST_VEND_LO: assert property ($fell(vend) |-> !vend[*3])
    else $error("credit pulse low time too short");
  AST_VEND_BUSY: assert property (vend |-> !busyN)
    else $error("credit pulse while not busy");
  AST_BUSY_END: assert property ($rose(busyN) |-> !vend[*8])
    else $error("credit pulse after busy released");
  AST_INH_RES: assert property (inhLine == (inhOeN | inhOut))
    else $error("inhibit line not pulled high when released");
  AST_INH_OD: assert property (inhOut == 4'h0)
    else $error("inhibit line driven high");
endmodule

// *** note_validator_host_interface_tb.sv ***
// Testbench: host APB end and validator end joined over the link
module note_validator_host_interface_tb;
  import nvh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic noteEnter, noteResult, noteOk, noteReturned;
  logic [3:0] noteChan;
  logic fastBaud, pulseMode, creditHold, escrowPinEn, stackNote, returnNote;
  logic [7:0] noteUnits;
  logic globalDisable, lowPower;
  logic [15:0] chanInhibit;
  int errCount = 0;
  int checks = 0;
  int cyc = 0;
  int stacks = 0;
  int returns = 0;
  nvh_link_if nvh_link_if_inst();
  nvh_host nvh_host_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(nvh_link_if_inst));
  // Short sleep and escrow counts keep the run brief
  nvh_device #(.SLEEP_FIRST(200), .SLEEP_AFTER(100), .ESC_TMO(500)) nvh_device_inst (
    .clk(clk), .rst(rst), .link(nvh_link_if_inst), .fastBaud(fastBaud),
    .pulseMode(pulseMode), .creditHold(creditHold), .lowPowerEn(1'b1),
    .escrowPinEn(escrowPinEn), .pulsesPerUnit(8'h02),
    .pulseHigh(16'h0004), .pulseLow(16'h0003), .noteEnter(noteEnter),
    .noteResult(noteResult), .noteOk(noteOk), .noteChan(noteChan), .noteUnits(noteUnits),
    .noteReturned(noteReturned), .stackNote(stackNote), .returnNote(returnNote),
    .globalDisable(globalDisable), .lowPower(lowPower), .chanInhibit(chanInhibit));
  nvh_link_chk nvh_link_chk_inst (.clk(clk), .rst(rst), .devTx(nvh_link_if_inst.devTx),
    .hostTx(nvh_link_if_inst.hostTx), .vend(nvh_link_if_inst.vend),
    .busyN(nvh_link_if_inst.busyN), .inhOut(nvh_link_if_inst.inhOut),
    .inhOeN(nvh_link_if_inst.inhOeN), .inhLine(nvh_link_if_inst.inhLine));
  // ----
  // Clock, timeout and tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ceiling covers five bytes at 9600 baud plus polling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errCount++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll for a received byte, then read and compare it
  task automatic getb(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (rd[STAT_RXV] !== 1'b1 && n < 20000);
    apb(1'b0, REG_RX, 32'h0);
    chk("rx byte", {24'h0, e}, rd);
  endtask
  // One-cycle sensor strobe: 0 note entry, 1 note result
  task automatic strobe(input bit res);
    @(posedge clk);
    if (res) noteResult <= 1'b1;
    else noteEnter <= 1'b1;
    @(posedge clk);
    noteEnter <= 1'b0;
    noteResult <= 1'b0;
  endtask
  // Mechanism strobes last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (stackNote) stacks++;
    if (returnNote) returns++;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {noteEnter, noteResult, noteOk, noteReturned, noteChan} = 8'h0;
    {fastBaud, pulseMode, creditHold, escrowPinEn, noteUnits} = 12'hc02;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("disabled", 32'h1, {31'h0, globalDisable});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, REG_CTRL, 32'h000000f1);
    repeat (4) @(posedge clk);
    chk("disabled", 32'h0, {31'h0, globalDisable});
    apb(1'b1, REG_TX, 32'h00000086);
    getb(8'h86);
    chk("inhibit ch4", 32'h1, {31'h0, chanInhibit[3]});
    chk("low power", 32'h1, {31'h0, lowPower});
    strobe(1'b0);
    getb(EV_BUSY);
    chk("woken", 32'h0, {31'h0, lowPower});
    chk("busy", 32'h0, {31'h0, nvh_link_if_inst.busyN});
    noteOk <= 1'b1;
    noteChan <= 4'h1;
    strobe(1'b1);
    getb(EV_READY);
    getb(8'h02);
    for (int n = 0; n < 20000 && nvh_link_if_inst.busyN !== 1'b1; n++) @(posedge clk);
    apb(1'b0, REG_CREDIT, 32'h0);
    chk("credit", 32'h4, rd);
    repeat (110) @(posedge clk);
    chk("low power", 32'h1, {31'h0, lowPower});
    // Credit hold: one unit per escrow rise; long wait shows no credit is paid before the first rise
    creditHold <= 1'b1;
    apb(1'b1, REG_CREDIT, 32'h0);
    strobe(1'b0);
    strobe(1'b1);
    repeat (2000) @(posedge clk);
    apb(1'b0, REG_CREDIT, 32'h0);
    chk("hold credit", 32'h0, rd);
    apb(1'b1, REG_CTRL, 32'h000000f3);
    apb(1'b1, REG_CTRL, 32'h000000f1);
    repeat (30) @(posedge clk);
    apb(1'b0, REG_CREDIT, 32'h0);
    chk("hold credit", 32'h2, rd);
    chk("hold busy", 32'h0, {31'h0, nvh_link_if_inst.busyN});
    apb(1'b1, REG_CTRL, 32'h000000f3);
    repeat (30) @(posedge clk);
    apb(1'b0, REG_CREDIT, 32'h0);
    chk("hold credit", 32'h4, rd);
    chk("hold busy", 32'h1, {31'h0, nvh_link_if_inst.busyN});
    chk("stacked", 32'h2, 32'(stacks));
    chk("returned", 32'h0, 32'(returns));
    wrap_up();
  end
endmodule
